// *** lmr_defines.svh ***
// Constants of the link method recognition handshake: frame codes,
// command numbers and timing counts.
// Assumes a single 250 MHz clock shared by both ends of the link.
`ifndef LMR_DEFINES_SVH
`define LMR_DEFINES_SVH

// Frame layout and command numbers.
`define LMR_START_CODE 8'h02
`define LMR_FTYPE_HI 8'hff
`define LMR_FTYPE_LO 8'hff
`define LMR_CMD_IFREQ 8'h00
`define LMR_CMD_IFRSP 8'h80
`define LMR_CMD_NOTE 8'h01
`define LMR_CMD_ACCEPT 8'h81
`define LMR_NOTE_OK 8'h00
`define LMR_NOTE_NG 8'h01
`define LMR_RSP_DL 2'd3
`define LMR_MAX_DL 16'h0003
`define LMR_FRAME_HDR 4'd7
`define LMR_NUM_SPEEDS 7

// Timing, each time in milliseconds and its count of clock cycles.
`define LMR_CLK_KHZ 250000
`define LMR_MS_TO_CYC(ms) ((ms) * `LMR_CLK_KHZ)
`define LMR_REPLY_DEADLINE_MS 300
`define LMR_TRANSITION_MS 500
`define LMR_RETRY_INTERVAL_MS 100
`define LMR_LISTEN_MS 1000
`define LMR_REPLY_CYC `LMR_MS_TO_CYC(`LMR_REPLY_DEADLINE_MS)
`define LMR_TRANSITION_CYC `LMR_MS_TO_CYC(`LMR_TRANSITION_MS)
`define LMR_RETRY_CYC `LMR_MS_TO_CYC(`LMR_RETRY_INTERVAL_MS)
`define LMR_LISTEN_CYC `LMR_MS_TO_CYC(`LMR_LISTEN_MS)
`define LMR_TIMER_W 28

`endif

// *** lmr_pkg.sv ***
// Types and frame functions shared by both ends of the link.
// Assumes lmr_defines.svh is on the include path.
`include "lmr_defines.svh"

package lmr_pkg;

  typedef enum logic [1:0] {
    LMR_UNREC,
    LMR_UNCONF,
    LMR_CONF,
    LMR_NOCONN
  } lmr_phase_t;

  typedef struct packed {
    logic [3:0] idx;
    logic [7:0] cmd;
    logic [7:0] fn;
    logic [15:0] dl;
    logic [23:0] data;
    logic [7:0] sum;
    logic done;
    logic bad;
  } lmr_rx_t;

  // Byte i of a frame, check code excepted; data is left aligned.
  function automatic logic [7:0] lmr_tx_byte(input logic [7:0] cmd,
      input logic [7:0] fn, input logic [1:0] dl, input logic [23:0] d,
      input logic [3:0] i);
    logic [7:0] b;
    case (i)
      4'd0: b = `LMR_START_CODE;
      4'd1: b = `LMR_FTYPE_HI;
      4'd2: b = `LMR_FTYPE_LO;
      4'd3: b = cmd;
      4'd4: b = fn;
      4'd5: b = 8'h00;
      4'd6: b = {6'h00, dl};
      4'd7: b = d[23:16];
      4'd8: b = d[15:8];
      default: b = d[7:0];
    endcase
    return b;
  endfunction

  // One received byte through the frame parser; data lands right aligned.
  // A wrong start code is skipped; a wrong type or check code ends the frame with bad set.
  function automatic lmr_rx_t lmr_rx_step(input lmr_rx_t s,
      input logic [7:0] b);
    lmr_rx_t n;
    n = s;
    n.done = 1'b0;
    n.bad = 1'b0;
    n.idx = s.idx + 4'd1;
    n.sum = s.sum + b;
    case (s.idx)
      4'd0: begin
        n.sum = 8'h00;
        if (b != `LMR_START_CODE) n.idx = 4'd0;
      end
      4'd1: n.bad = (b != `LMR_FTYPE_HI);
      4'd2: n.bad = (b != `LMR_FTYPE_LO);
      4'd3: n.cmd = b;
      4'd4: n.fn = b;
      4'd5: n.dl[15:8] = b;
      4'd6: begin
        n.dl[7:0] = b;
        n.bad = ({s.dl[15:8], b} > `LMR_MAX_DL);
      end
      default: begin
        if (s.idx == `LMR_FRAME_HDR + s.dl[3:0]) begin
          n.done = (b == s.sum);
          n.bad = (b != s.sum);
        end else begin
          n.data = {s.data[15:0], b};
        end
      end
    endcase
    if (n.done || n.bad) n.idx = 4'd0;
    return n;
  endfunction

  // Next available line speed after cur, wrapping round the list.
  function automatic logic [2:0] lmr_next_speed(input logic [6:0] m,
      input logic [2:0] cur);
    logic [2:0] n;
    int j;
    n = cur;
    for (int k = `LMR_NUM_SPEEDS; k >= 1; k--) begin
      j = (int'(cur) + k) % `LMR_NUM_SPEEDS;
      if (m[j]) n = 3'(j);
    end
    return n;
  endfunction

endpackage

// *** lmr_link_if.sv ***
// Byte link between adapter and equipment, one byte per valid cycle.
// Each direction carries its sender's line speed; a receiver takes a
// byte only when that speed equals its own.
`timescale 1ns/1ns

interface lmr_link_if;
  logic a2e_valid;
  logic [7:0] a2e_data;
  logic [2:0] a2e_speed;
  logic e2a_valid;
  logic [7:0] e2a_data;
  logic [2:0] e2a_speed;

  modport adapter (
    output a2e_valid,
    output a2e_data,
    output a2e_speed,
    input e2a_valid,
    input e2a_data,
    input e2a_speed
  );

  modport equipment (
    input a2e_valid,
    input a2e_data,
    input a2e_speed,
    output e2a_valid,
    output e2a_data,
    output e2a_speed
  );
endinterface

// *** lmr_adapter.sv ***
// Adapter end of the link method recognition handshake.
// Assumes the equipment end shares the clock and that the user logic
// runs the per-method confirmation procedure on request.
//
// Summary of operation
// - Empty response: start, type, command, number, length, check.
// - Response echoes frame number; length is zero.
// - Stay unrecognised until recognition succeeds.
// - Try one speed, then the next available.
// - Use the recognised method for later traffic.
// - Recover on failure, else return to unrecognised.
// - Wait at least 500 ms before method traffic.
// - Recognition replies sent within 300 ms.
// - Unreadable response: retry after retry interval.
// - Equipment waits for the adapter's request.
// - Negative notification sends equipment back to waiting.
// - Positive notification: equipment accepts, goes unconfirmed.
// - Adapter keeps requesting at intervals while unrecognised.
// - Cycle two or more speeds, interval above retry.
// - Supported method: notify, unconfirmed after acceptance.
// - Unsupported method: notify, connection not possible.
// - No acceptance in 300 ms: request again.
// - Confirm the method, then enter confirmed.
// - Power-on state is a configuration option.
// - Adapter may rerun confirmation after a failure.
`timescale 1ns/1ns

module lmr_adapter
  import lmr_pkg::*;
#(
  parameter logic [6:0] SPEED_MASK = 7'h7f,
  parameter logic [7:0] TYPE_MASK = 8'h03,
  parameter bit START_RECOGNISED = 1'b0,
  parameter logic [2:0] START_SPEED = 3'd2,
  parameter int unsigned RETRY_CYC = `LMR_RETRY_CYC,
  parameter int unsigned REPLY_CYC = `LMR_REPLY_CYC,
  parameter int unsigned TRANS_CYC = `LMR_TRANSITION_CYC,
  parameter int unsigned MAX_RECOVER = 3
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic resetn,
  // Link towards the equipment.
  lmr_link_if.adapter link,
  // Confirmation procedure of the recognised method.
  output logic confirm_start,
  input wire logic confirm_ok,
  input wire logic confirm_fail,
  input wire logic comm_fail,
  // Recognition result.
  output lmr_phase_t phase,
  output logic [2:0] line_speed,
  output logic [7:0] method_type,
  output logic [7:0] method_iface
);

  typedef enum logic [3:0] {
    A_WAIT,
    A_REQ,
    A_RESP,
    A_NOTE,
    A_ACC,
    A_NOCONN,
    A_TRANS,
    A_UNCONF,
    A_CONF
  } lmr_adp_state_t;

  lmr_adp_state_t state_q;
  logic [`LMR_TIMER_W-1:0] timer_q;
  logic [2:0] speed_q;
  logic [7:0] fn_q;
  logic [3:0] rec_q;
  logic ok_q;
  logic [7:0] type_q;
  logic [7:0] iface_q;
  logic confirm_start_q;
  logic tx_go_q;
  logic [7:0] tx_cmd_q;
  logic [1:0] tx_dl_q;
  logic [23:0] tx_data_q;
  logic tx_busy_q;
  logic [3:0] tx_idx_q;
  logic [7:0] tx_sum_q;
  logic a2e_valid_q;
  logic [7:0] a2e_data_q;
  lmr_rx_t rx_q;
  logic tx_last;
  logic tx_done;
  logic [7:0] tx_byte;
  logic method_ok;

  function automatic logic expired(input int unsigned n);
    return timer_q >= `LMR_TIMER_W'(n - 1);
  endfunction

  // Frame transmitter; the check code is the byte sum after the start.
  assign tx_last = (tx_idx_q == `LMR_FRAME_HDR + {2'b00, tx_dl_q});
  assign tx_done = tx_busy_q && tx_last;
  assign tx_byte = tx_last ? tx_sum_q :
      lmr_tx_byte(tx_cmd_q, fn_q, tx_dl_q, tx_data_q, tx_idx_q);

  always_ff @(posedge clock) begin
    if (!resetn) begin
      tx_busy_q <= 1'b0;
      tx_idx_q <= 4'd0;
      tx_sum_q <= 8'h00;
      a2e_valid_q <= 1'b0;
      a2e_data_q <= 8'h00;
    end else begin
      a2e_valid_q <= tx_busy_q;
      a2e_data_q <= tx_byte;
      if (tx_busy_q) begin
        tx_sum_q <= (tx_idx_q == 4'd0) ? 8'h00 : tx_sum_q + tx_byte;
        tx_idx_q <= tx_last ? 4'd0 : tx_idx_q + 4'd1;
        tx_busy_q <= !tx_last;
      end else if (tx_go_q) begin
        tx_busy_q <= 1'b1;
      end
    end
  end

  // Receiver; bytes sent at another speed are lost, as on a real line.
  always_ff @(posedge clock) begin
    if (!resetn) begin
      rx_q <= '0;
    end else if (link.e2a_valid && link.e2a_speed == speed_q) begin
      rx_q <= lmr_rx_step(rx_q, link.e2a_data);
    end else begin
      rx_q.done <= 1'b0;
      rx_q.bad <= 1'b0;
    end
  end

  // The reported speed must be the one now in use to be accepted.
  assign method_ok = ((rx_q.data[23:16] & TYPE_MASK) != 8'h00) &&
      (rx_q.data[15:8] == {5'h00, speed_q}) && SPEED_MASK[speed_q];

  always_ff @(posedge clock) begin
    if (!resetn) begin
      state_q <= START_RECOGNISED ? A_TRANS : A_WAIT;
      timer_q <= '0;
      speed_q <= START_SPEED;
      fn_q <= 8'h00;
      rec_q <= 4'd0;
      ok_q <= 1'b0;
      type_q <= 8'h00;
      iface_q <= 8'h00;
      confirm_start_q <= 1'b0;
      tx_go_q <= 1'b0;
      tx_cmd_q <= 8'h00;
      tx_dl_q <= 2'd0;
      tx_data_q <= 24'h000000;
    end else begin
      timer_q <= timer_q + 1'b1;
      tx_go_q <= 1'b0;
      confirm_start_q <= 1'b0;
      case (state_q)
        A_WAIT: begin
          if (expired(RETRY_CYC)) begin
            state_q <= A_REQ;
            fn_q <= fn_q + 8'h01;
            tx_go_q <= 1'b1;
            tx_cmd_q <= `LMR_CMD_IFREQ;
            tx_dl_q <= 2'd0;
          end
        end
        A_REQ: begin
          if (tx_done) begin
            state_q <= A_RESP;
            timer_q <= '0;
          end
        end
        A_RESP: begin
          if (rx_q.done && rx_q.cmd == `LMR_CMD_IFRSP && rx_q.fn == fn_q)
          begin
            state_q <= A_NOTE;
            type_q <= rx_q.data[23:16];
            iface_q <= rx_q.data[7:0];
            ok_q <= method_ok;
            tx_go_q <= 1'b1;
            tx_cmd_q <= `LMR_CMD_NOTE;
            tx_dl_q <= 2'd1;
            tx_data_q <= {method_ok ? `LMR_NOTE_OK : `LMR_NOTE_NG, 16'h0000};
          end else if (rx_q.bad) begin
            state_q <= A_WAIT;
            timer_q <= '0;
          end else if (expired(REPLY_CYC)) begin
            state_q <= A_WAIT;
            timer_q <= '0;
            speed_q <= lmr_next_speed(SPEED_MASK, speed_q);
          end
        end
        A_NOTE: begin
          if (tx_done) begin
            state_q <= ok_q ? A_ACC : A_NOCONN;
            timer_q <= '0;
          end
        end
        A_ACC: begin
          if (rx_q.done && rx_q.cmd == `LMR_CMD_ACCEPT &&
              rx_q.fn == fn_q && rx_q.dl == 16'h0000) begin
            state_q <= A_TRANS;
            timer_q <= '0;
          end else if (expired(REPLY_CYC)) begin
            state_q <= A_REQ;
            fn_q <= fn_q + 8'h01;
            tx_go_q <= 1'b1;
            tx_cmd_q <= `LMR_CMD_IFREQ;
            tx_dl_q <= 2'd0;
          end
        end
        A_NOCONN: begin
          timer_q <= '0;
        end
        A_TRANS: begin
          if (expired(TRANS_CYC)) begin
            state_q <= A_UNCONF;
            confirm_start_q <= 1'b1;
          end
        end
        A_UNCONF, A_CONF: begin
          if (state_q == A_UNCONF && confirm_ok) begin
            state_q <= A_CONF;
            rec_q <= 4'd0;
          end else if ((state_q == A_UNCONF && confirm_fail) ||
              (state_q == A_CONF && comm_fail)) begin
            timer_q <= '0;
            if (rec_q < 4'(MAX_RECOVER)) begin
              state_q <= A_UNCONF;
              rec_q <= rec_q + 4'd1;
              confirm_start_q <= 1'b1;
            end else begin
              state_q <= A_WAIT;
              rec_q <= 4'd0;
            end
          end
        end
        default: begin
          state_q <= A_WAIT;
        end
      endcase
    end
  end

  always_comb begin
    case (state_q)
      A_NOCONN: phase = LMR_NOCONN;
      A_TRANS, A_UNCONF: phase = LMR_UNCONF;
      A_CONF: phase = LMR_CONF;
      default: phase = LMR_UNREC;
    endcase
  end

  // The method stays latched so that later traffic keeps using it.
  assign method_type = type_q;
  assign method_iface = iface_q;
  assign line_speed = speed_q;
  assign confirm_start = confirm_start_q;
  assign link.a2e_valid = a2e_valid_q;
  assign link.a2e_data = a2e_data_q;
  assign link.a2e_speed = speed_q;

endmodule

// *** lmr_equipment.sv ***
// Equipment end of the link method recognition handshake.
// Assumes the adapter end shares the clock and that the user logic
// runs the per-method confirmation procedure on request.
`timescale 1ns/1ns

module lmr_equipment
  import lmr_pkg::*;
#(
  parameter logic [6:0] SPEED_MASK = 7'h7f,
  parameter logic [7:0] EQ_TYPE = 8'h01,
  parameter logic [7:0] EQ_IFACE = 8'h40,
  parameter bit START_RECOGNISED = 1'b0,
  parameter logic [2:0] START_SPEED = 3'd2,
  parameter int unsigned LISTEN_CYC = `LMR_LISTEN_CYC,
  parameter int unsigned TRANS_CYC = `LMR_TRANSITION_CYC,
  parameter int unsigned MAX_RECOVER = 3
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic resetn,
  // Link towards the adapter.
  lmr_link_if.equipment link,
  // Confirmation procedure of the recognised method.
  output logic confirm_start,
  input wire logic confirm_ok,
  input wire logic confirm_fail,
  input wire logic comm_fail,
  // Recognition result.
  output lmr_phase_t phase,
  output logic [2:0] line_speed
);

  typedef enum logic [2:0] {
    E_LISTEN,
    E_DATA,
    E_NOTE,
    E_ACC,
    E_TRANS,
    E_UNCONF,
    E_CONF
  } lmr_eq_state_t;

  lmr_eq_state_t state_q;
  logic [`LMR_TIMER_W-1:0] timer_q;
  logic [2:0] speed_q;
  logic [7:0] fn_q;
  logic [3:0] rec_q;
  logic confirm_start_q;
  logic tx_go_q;
  logic [7:0] tx_cmd_q;
  logic [1:0] tx_dl_q;
  logic [23:0] tx_data_q;
  logic tx_busy_q;
  logic [3:0] tx_idx_q;
  logic [7:0] tx_sum_q;
  logic e2a_valid_q;
  logic [7:0] e2a_data_q;
  lmr_rx_t rx_q;
  logic tx_last;
  logic tx_done;
  logic [7:0] tx_byte;

  function automatic logic expired(input int unsigned n);
    return timer_q >= `LMR_TIMER_W'(n - 1);
  endfunction

  assign tx_last = (tx_idx_q == `LMR_FRAME_HDR + {2'b00, tx_dl_q});
  assign tx_done = tx_busy_q && tx_last;
  assign tx_byte = tx_last ? tx_sum_q :
      lmr_tx_byte(tx_cmd_q, fn_q, tx_dl_q, tx_data_q, tx_idx_q);

  always_ff @(posedge clock) begin
    if (!resetn) begin
      tx_busy_q <= 1'b0;
      tx_idx_q <= 4'd0;
      tx_sum_q <= 8'h00;
      e2a_valid_q <= 1'b0;
      e2a_data_q <= 8'h00;
    end else begin
      e2a_valid_q <= tx_busy_q;
      e2a_data_q <= tx_byte;
      if (tx_busy_q) begin
        tx_sum_q <= (tx_idx_q == 4'd0) ? 8'h00 : tx_sum_q + tx_byte;
        tx_idx_q <= tx_last ? 4'd0 : tx_idx_q + 4'd1;
        tx_busy_q <= !tx_last;
      end else if (tx_go_q) begin
        tx_busy_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      rx_q <= '0;
    end else if (link.a2e_valid && link.a2e_speed == speed_q) begin
      rx_q <= lmr_rx_step(rx_q, link.a2e_data);
    end else begin
      rx_q.done <= 1'b0;
      rx_q.bad <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      state_q <= START_RECOGNISED ? E_TRANS : E_LISTEN;
      timer_q <= '0;
      speed_q <= START_SPEED;
      fn_q <= 8'h00;
      rec_q <= 4'd0;
      confirm_start_q <= 1'b0;
      tx_go_q <= 1'b0;
      tx_cmd_q <= 8'h00;
      tx_dl_q <= 2'd0;
      tx_data_q <= 24'h000000;
    end else begin
      timer_q <= timer_q + 1'b1;
      tx_go_q <= 1'b0;
      confirm_start_q <= 1'b0;
      case (state_q)
        E_LISTEN: begin
          if (rx_q.done && rx_q.cmd == `LMR_CMD_IFREQ) begin
            state_q <= E_DATA;
            fn_q <= rx_q.fn;
            tx_go_q <= 1'b1;
            tx_cmd_q <= `LMR_CMD_IFRSP;
            tx_dl_q <= `LMR_RSP_DL;
            tx_data_q <= {EQ_TYPE, 5'h00, speed_q, EQ_IFACE};
          end else if (expired(LISTEN_CYC)) begin
            timer_q <= '0;
            speed_q <= lmr_next_speed(SPEED_MASK, speed_q);
          end
        end
        E_DATA: begin
          if (tx_done) begin
            state_q <= E_NOTE;
            timer_q <= '0;
          end
        end
        E_NOTE: begin
          if (rx_q.done && rx_q.cmd == `LMR_CMD_NOTE && rx_q.fn == fn_q)
          begin
            timer_q <= '0;
            if (rx_q.data[7:0] == `LMR_NOTE_OK) begin
              state_q <= E_ACC;
              tx_go_q <= 1'b1;
              tx_cmd_q <= `LMR_CMD_ACCEPT;
              tx_dl_q <= 2'd0;
            end else begin
              state_q <= E_LISTEN;
            end
          end else if (expired(LISTEN_CYC)) begin
            state_q <= E_LISTEN;
            timer_q <= '0;
          end
        end
        E_ACC: begin
          if (tx_done) begin
            state_q <= E_TRANS;
            timer_q <= '0;
          end
        end
        E_TRANS: begin
          if (expired(TRANS_CYC)) begin
            state_q <= E_UNCONF;
            confirm_start_q <= 1'b1;
          end
        end
        E_UNCONF, E_CONF: begin
          if (state_q == E_UNCONF && confirm_ok) begin
            state_q <= E_CONF;
            rec_q <= 4'd0;
          end else if ((state_q == E_UNCONF && confirm_fail) ||
              (state_q == E_CONF && comm_fail)) begin
            timer_q <= '0;
            if (rec_q < 4'(MAX_RECOVER)) begin
              state_q <= E_UNCONF;
              rec_q <= rec_q + 4'd1;
              confirm_start_q <= 1'b1;
            end else begin
              state_q <= E_LISTEN;
              rec_q <= 4'd0;
            end
          end
        end
        default: begin
          state_q <= E_LISTEN;
        end
      endcase
    end
  end

  always_comb begin
    case (state_q)
      E_TRANS, E_UNCONF: phase = LMR_UNCONF;
      E_CONF: phase = LMR_CONF;
      default: phase = LMR_UNREC;
    endcase
  end

  assign line_speed = speed_q;
  assign confirm_start = confirm_start_q;
  assign link.e2a_valid = e2a_valid_q;
  assign link.e2a_data = e2a_data_q;
  assign link.e2a_speed = speed_q;

endmodule

// *** lmr_link_chk.sv ***
// Concurrent checks on the byte link that joins the two ends.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/1ns

module lmr_link_chk (
  // Clock and reset.
  input wire logic clock,
  input wire logic resetn,
  // Adapter to equipment.
  input wire logic a2e_valid,
  input wire logic [7:0] a2e_data,
  input wire logic [2:0] a2e_speed,
  // Equipment to adapter.
  input wire logic e2a_valid,
  input wire logic [7:0] e2a_data,
  input wire logic [2:0] e2a_speed
);
  logic [3:0] a_idx_q;
  logic [3:0] e_idx_q;
  logic [7:0] a_cmd_q;
  logic [7:0] req_fn_q;
  logic [7:0] e_cmd_q;
  logic [7:0] e_sum_q;
  logic [7:0] e_last_q;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  always_ff @(posedge clock) begin
    if (!resetn || !a2e_valid) a_idx_q <= 4'h0;
    else a_idx_q <= a_idx_q + 4'h1;
  end

  // Only request frames set the number that an acceptance must echo.
  always_ff @(posedge clock) begin
    if (a2e_valid && a_idx_q == 4'h3) a_cmd_q <= a2e_data;
    if (a2e_valid && a_idx_q == 4'h4 && a_cmd_q == 8'h00) begin
      req_fn_q <= a2e_data;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn || !e2a_valid) e_idx_q <= 4'h0;
    else e_idx_q <= e_idx_q + 4'h1;
  end

  always_ff @(posedge clock) begin
    if (e2a_valid) begin
      e_last_q <= e2a_data;
      e_sum_q <= (e_idx_q == 4'h0) ? 8'h00 : e_sum_q + e2a_data;
      if (e_idx_q == 4'h3) e_cmd_q <= e2a_data;
    end
  end

  a_a2e_head: assert property ($rose(a2e_valid) |->
    a2e_data == 8'h02 ##1 a2e_data == 8'hff ##1 a2e_data == 8'hff)
    else $error("adapter frame header wrong");
  a_e2a_head: assert property ($rose(e2a_valid) |->
    e2a_data == 8'h02 ##1 e2a_data == 8'hff ##1 e2a_data == 8'hff)
    else $error("equipment frame header wrong");
  a_len_high: assert property (e2a_valid && e_idx_q == 4'h5 |->
    e2a_data == 8'h00)
    else $error("length high byte not zero");
  a_accept_empty: assert property (e2a_valid && e_idx_q == 4'h4 &&
    e_cmd_q == 8'h81 |-> e2a_data == req_fn_q ##1 e2a_data == 8'h00
    ##1 e2a_data == 8'h00 ##1 e2a_valid ##1 !e2a_valid)
    else $error("acceptance frame not empty or wrong number");
  a_check_sum: assert property ($fell(e2a_valid) |->
    e_last_q == 8'(e_sum_q - e_last_q))
    else $error("equipment check code wrong");
  a_reply_gap: assert property ($rose(e2a_valid) |->
    $past(a2e_valid, 4) && !$past(a2e_valid, 3))
    else $error("equipment sent without a request");
  a_speed_hold: assert property (e2a_valid && $past(e2a_valid) |->
    $stable(e2a_speed) && e2a_speed == a2e_speed)
    else $error("speed changed inside a frame");
  a_speed_code: assert property (a2e_speed <= 3'h6 &&
    e2a_speed <= 3'h6)
    else $error("speed code out of range");
  a_frame_len: assert property (a2e_valid |-> a_idx_q < 4'h9)
    else $error("adapter frame too long");

  c_reply: cover property ($rose(e2a_valid));
  c_notify: cover property (a2e_valid && a_idx_q == 4'h4 &&
    a_cmd_q == 8'h01);
  c_accept: cover property (e2a_valid && e_idx_q == 4'h4 &&
    e_cmd_q == 8'h81);
endmodule

// *** lmr_tb.sv ***
// Testbench: two adapter and equipment pairs, one that can agree and
// one whose adapter rejects the method. Counts are shortened.
`timescale 1ns/1ns

`define CHK(got, exp) \
  begin \
    n_tests++; \
    if ((got) !== (exp)) begin \
      num_errors++; \
      $display("[ERR] t=%0t got=%h exp=%h", $time, (got), (exp)); \
    end \
  end

module tb
  import lmr_pkg::*;
;
  typedef struct packed {
    logic sel;
    logic [3:0] idx;
    logic [7:0] exp;
  } lmr_row_t;

  logic clock = 1'b0;
  logic resetn;
  logic [2:0] ad_ctl;
  logic [2:0] eq_ctl;
  logic ad_start, eq_start;
  lmr_phase_t ad_phase, eq_phase, b_phase, b_eq_phase;
  logic [2:0] ad_speed, eq_speed;
  logic [7:0] ad_type, ad_iface, got, s, req_fn;
  logic [7:0] abuf [16];
  logic [7:0] ebuf [16];
  logic [7:0] notif [16];
  logic [7:0] accf [16];
  int ai = 0, ei = 0, cyc = 0, n_start = 0, st_cyc = 0, n_eq_start = 0;
  int t0, n0, k, num_errors = 0, n_tests = 0;
  // Notification (sel 0) and acceptance (sel 1) bytes with fixed values.
  lmr_row_t rows [13] = '{'{1'b0, 4'h0, 8'h02}, '{1'b0, 4'h1, 8'hff},
    '{1'b0, 4'h2, 8'hff}, '{1'b0, 4'h3, 8'h01}, '{1'b0, 4'h5, 8'h00},
    '{1'b0, 4'h6, 8'h01}, '{1'b0, 4'h7, 8'h00}, '{1'b1, 4'h0, 8'h02},
    '{1'b1, 4'h1, 8'hff}, '{1'b1, 4'h2, 8'hff}, '{1'b1, 4'h3, 8'h81},
    '{1'b1, 4'h5, 8'h00}, '{1'b1, 4'h6, 8'h00}};

  lmr_link_if link();
  lmr_link_if link_b();

  // Both ends start at the same speed, so the long reply and dwell
  // times keep their defaults: no scenario waits for them to run out.
  lmr_adapter #(.RETRY_CYC(40), .TRANS_CYC(50)) lmr_adapter_i (
    .clock(clock), .resetn(resetn),
    .link(link.adapter), .confirm_start(ad_start), .confirm_ok(ad_ctl[2]),
    .confirm_fail(ad_ctl[1]), .comm_fail(ad_ctl[0]), .phase(ad_phase),
    .line_speed(ad_speed), .method_type(ad_type), .method_iface(ad_iface));
  lmr_equipment #(.TRANS_CYC(50)) lmr_equipment_i (
    .clock(clock), .resetn(resetn), .link(link.equipment),
    .confirm_start(eq_start), .confirm_ok(eq_ctl[2]),
    .confirm_fail(eq_ctl[1]), .comm_fail(eq_ctl[0]), .phase(eq_phase),
    .line_speed(eq_speed));
  // This adapter's mask excludes the equipment's type, so it must refuse.
  lmr_adapter #(.TYPE_MASK(8'h02), .RETRY_CYC(40)) lmr_adapter_b_i (
    .clock(clock), .resetn(resetn),
    .link(link_b.adapter), .confirm_start(), .confirm_ok(ad_ctl[2]),
    .confirm_fail(ad_ctl[1]), .comm_fail(ad_ctl[0]), .phase(b_phase),
    .line_speed(), .method_type(), .method_iface());
  lmr_equipment lmr_equipment_b_i (
    .clock(clock), .resetn(resetn), .link(link_b.equipment),
    .confirm_start(), .confirm_ok(eq_ctl[2]), .confirm_fail(eq_ctl[1]),
    .comm_fail(eq_ctl[0]), .phase(b_eq_phase), .line_speed());

  lmr_link_chk lmr_link_chk_i (.clock(clock), .resetn(resetn),
    .a2e_valid(link.a2e_valid), .a2e_data(link.a2e_data),
    .a2e_speed(link.a2e_speed), .e2a_valid(link.e2a_valid),
    .e2a_data(link.e2a_data), .e2a_speed(link.e2a_speed));

  always #2 clock = ~clock;

  task automatic end_of_test();
    if (num_errors == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic tick();
    @(posedge clock);
    #1;
  endtask

  task automatic pulse(input bit eq, input logic [2:0] v);
    @(posedge clock);
    if (eq) eq_ctl <= v;
    else ad_ctl <= v;
    @(posedge clock);
    eq_ctl <= 3'h0;
    ad_ctl <= 3'h0;
    #1;
  endtask

  // Cycle count, hang limit, start pulses and frame capture.
  always @(posedge clock) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      end_of_test();
    end
    if (ad_start === 1'b1) begin
      n_start++;
      st_cyc = cyc;
    end
    if (eq_start === 1'b1) n_eq_start++;
    if (link.a2e_valid === 1'b1) begin
      abuf[ai] = link.a2e_data;
      ai++;
    end else if (ai > 0) begin
      if (abuf[3] == 8'h00) req_fn = abuf[4];
      if (abuf[3] == 8'h01) notif = abuf;
      ai = 0;
    end
    if (link.e2a_valid === 1'b1) begin
      ebuf[ei] = link.e2a_data;
      ei++;
    end else if (ei > 0) begin
      if (ebuf[3] == 8'h81) accf = ebuf;
      ei = 0;
    end
  end

  initial begin
    resetn = 1'b0;
    ad_ctl = 3'h0;
    eq_ctl = 3'h0;
    repeat (3) @(posedge clock);
    resetn <= 1'b1;
    tick();
    `CHK(ad_phase, LMR_UNREC)
    `CHK(eq_phase, LMR_UNREC)
    while (ad_phase !== LMR_UNCONF) tick();
    t0 = cyc;
    for (int i = 0; i < 13; i++) begin
      got = rows[i].sel ? accf[rows[i].idx] : notif[rows[i].idx];
      `CHK(got, rows[i].exp)
    end
    s = 8'h00;
    for (int i = 1; i < 8; i++) s = s + notif[i];
    `CHK(notif[8], s)
    `CHK(accf[4], req_fn)
    `CHK(accf[7], 8'hff + 8'hff + 8'h81 + req_fn)
    `CHK(ad_type, 8'h01)
    `CHK(ad_iface, 8'h40)
    `CHK(ad_speed, eq_speed)
    `CHK(eq_phase, LMR_UNCONF)
    while (n_start == 0) tick();
    `CHK(st_cyc - t0 >= 50, 1'b1)
    pulse(1'b1, 3'h4);
    tick();
    `CHK(eq_phase, LMR_CONF)
    `CHK(n_eq_start, 1)
    pulse(1'b0, 3'h4);
    tick();
    `CHK(ad_phase, LMR_CONF)
    // A link failure, then every rerun of confirmation fails too.
    n0 = n_start;
    pulse(1'b0, 3'h1);
    for (int r = 0; r < 5; r++) begin
      k = n_start;
      repeat (10) if (n_start == k) tick();
      if (n_start != k) pulse(1'b0, 3'h2);
    end
    `CHK(n_start - n0, 3)
    `CHK(ad_phase, LMR_UNREC)
    `CHK(b_phase, LMR_NOCONN)
    `CHK(b_eq_phase, LMR_UNREC)
    end_of_test();
  end
endmodule
